// ### rtl/host_cmd_sts.v
// Purpose: Command and status registers of the high-speed host controller core
// Assumes: Register port is single-cycle; all inputs synchronous to clock
// Notes:   Read data appears one cycle after rd; outputs are all flip-flops
`timescale 1ns/100ps
`include "host_cmd_sts_consts.vh"

module host_cmd_sts (
	input  wire                     clock,
	input  wire                     nrst,
	input  wire [`ADDR_W-1:0]       addr,
	input  wire                     wr,
	input  wire [31:0]              wdata,
	input  wire                     rd,
	input  wire                     programmable_list_capable,
	input  wire [`FRINDEX_W-1:0]    frame_index,
	input  wire                     pipeline_idle,
	input  wire                     internal_error,
	input  wire [`STS_EVENTS-1:0]   event_in,
	input  wire                     async_sched_state,
	input  wire                     periodic_sched_state,
	input  wire                     empty_async_detect,
	output reg  [31:0]              rdata,
	output reg                      schedule_run,
	output reg                      core_reset,
	output reg                      abort_transaction,
	output reg                      ports_to_companion,
	output reg  [1:0]               frame_list_size,
	output reg  [`LIST_IDX_W-1:0]   list_index
);

	localparam ST_HALTED   = 2'h0;
	localparam ST_RUNNING  = 2'h1;
	localparam ST_STOPPING = 2'h2;

	reg  [1:0]              state;
	reg  [1:0]              next_state;
	reg                     run_control;
	reg                     halted_flag;
	reg  [`STS_EVENTS-1:0]  events;
	reg  [`SRST_CNT_W-1:0]  srst_count;
	reg                     srst_busy;

	wire wr_cmd = wr && (addr == `OFS_HOST_COMMAND);
	wire wr_sts = wr && (addr == `OFS_HOST_STATUS);
	// Writes are ignored while the controller reset runs
	wire cmd_take = wr_cmd && !srst_busy;
	wire srst_start = cmd_take && wdata[`CMD_SRST_BIT];
	wire run_write = cmd_take && !wdata[`CMD_SRST_BIT];

	// An internal error drops the run bit just like software would
	wire run_drop = internal_error && run_control;

	always @* begin
		next_state = state;
		case (state)
			ST_HALTED: begin
				if (run_control)
					next_state = ST_RUNNING;
			end
			ST_RUNNING: begin
				if (!run_control)
					next_state = ST_STOPPING;
			end
			ST_STOPPING: begin
				if (run_control)
					next_state = ST_RUNNING;
				else if (pipeline_idle)
					next_state = ST_HALTED;
			end
			default: next_state = ST_HALTED;
		endcase
	end

	always @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			srst_busy  <= 1'b0;
			srst_count <= {`SRST_CNT_W{1'b0}};
		end else if (srst_start && !srst_busy) begin
			srst_busy  <= 1'b1;
			srst_count <= `SRST_LOAD;
		end else if (srst_busy) begin
			if (srst_count == {`SRST_CNT_W{1'b0}})
				srst_busy <= 1'b0;
			else
				srst_count <= srst_count - 1'b1;
		end
	end

	always @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			state           <= ST_HALTED;
			run_control     <= 1'b0;
			halted_flag     <= `HALT_RESET;
			frame_list_size <= `FLS_RESET;
			events          <= {`STS_EVENTS{1'b0}};
		end else if (srst_busy) begin
			// operational state back to initial values
			state           <= ST_HALTED;
			run_control     <= 1'b0;
			halted_flag     <= `HALT_RESET;
			frame_list_size <= `FLS_RESET;
			events          <= {`STS_EVENTS{1'b0}};
		end else begin
			state <= next_state;
			if (run_write)
				run_control <= wdata[`CMD_RUN_BIT];
			else if (run_drop)
				run_control <= 1'b0;
			// halted cleared on run, set after drain
			if (run_write && wdata[`CMD_RUN_BIT])
				halted_flag <= 1'b0;
			else if (state == ST_STOPPING && !run_control && pipeline_idle)
				halted_flag <= 1'b1;
			if (run_write && programmable_list_capable)
				frame_list_size <= wdata[`CMD_FLS_HI:`CMD_FLS_LO];
			// write one clears, new event wins
			events <= event_in | (events & ~(wr_sts ? wdata[`STS_EVENTS-1:0] : {`STS_EVENTS{1'b0}}));
		end
	end

	wire [`LIST_IDX_W-1:0] raw_index = frame_index[`LIST_IDX_LO+`LIST_IDX_W-1:`LIST_IDX_LO];
	reg  [`LIST_IDX_W-1:0] index_mask;
	always @* begin
		// size decode; reserved code treated as smallest
		case (frame_list_size)
			`FLS_1024: index_mask = `MASK_1024;
			`FLS_512:  index_mask = `MASK_512;
			default:   index_mask = `MASK_256;
		endcase
	end

	wire [31:0] status_word = {16'h0000, async_sched_state, periodic_sched_state, empty_async_detect,
		halted_flag, 6'h00, events};
	wire [31:0] command_word = {28'h0000000, frame_list_size, srst_busy, run_control};

	always @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			rdata              <= 32'h00000000;
			schedule_run       <= 1'b0;
			core_reset         <= 1'b0;
			abort_transaction  <= 1'b0;
			ports_to_companion <= 1'b0;
			list_index         <= {`LIST_IDX_W{1'b0}};
		end else begin
			if (rd) begin
				if (addr == `OFS_HOST_COMMAND)
					rdata <= command_word;
				else if (addr == `OFS_HOST_STATUS)
					rdata <= status_word;
				else
					rdata <= 32'h00000000;
			end
			// Schedule keeps issuing only while running; stopping lets the pipe drain
			schedule_run <= run_control && !srst_busy && !run_drop;
			core_reset <= srst_busy;
			// abort at once; no bus reset is ever driven from here
			abort_transaction <= srst_busy;
			ports_to_companion <= srst_busy;
			list_index <= raw_index & index_mask;
		end
	end

endmodule // host_cmd_sts

// ### rtl/host_cmd_sts_consts.vh
// Purpose: Named constants for the host command and status registers
// Assumes: Registers sit at operational-space byte offsets
// Notes:   Included by host_cmd_sts.v only
`ifndef HOST_CMD_STS_CONSTS_VH
`define HOST_CMD_STS_CONSTS_VH

`define ADDR_W              8
`define OFS_HOST_COMMAND    8'h20
`define OFS_HOST_STATUS     8'h24

`define CMD_RUN_BIT         0
`define CMD_SRST_BIT        1
`define CMD_FLS_LO          2
`define CMD_FLS_HI          3

`define STS_XFER_BIT        0
`define STS_ERR_BIT         1
`define STS_PORT_BIT        2
`define STS_ROLL_BIT        3
`define STS_SYSERR_BIT      4
`define STS_ADV_BIT         5
`define STS_EVENTS          6
`define STS_HALT_BIT        12
`define STS_EMPTY_BIT       13
`define STS_PER_BIT         14
`define STS_ASYNC_BIT       15

`define FLS_1024            2'h0
`define FLS_512             2'h1
`define FLS_256             2'h2
`define FLS_RESET           2'h0

`define HALT_RESET          1'b1

`define FRINDEX_W           14
`define LIST_IDX_W          10
`define LIST_IDX_LO         3
`define MASK_1024           10'h3ff
`define MASK_512            10'h1ff
`define MASK_256            10'h0ff

// Length of the self-timed controller reset
`define SRST_TIME_NS        800
`define CLOCK_NS            50
`define SRST_CYCLES         ((`SRST_TIME_NS + `CLOCK_NS - 1) / `CLOCK_NS)
`define SRST_CNT_W          5
// Counter load so that busy stands for exactly SRST_CYCLES cycles
`define SRST_LOAD           5'h0f

`endif

// ### testbench/core_model.sv
// Purpose: Schedule engine stand-in
// Assumes: Shares the block clock
// Notes:   slow gives a long drain
`timescale 1ns/100ps
module core_model (
	input wire clock, nrst, schedule_run, core_reset, slow,
	output reg pipeline_idle,
	output reg [13:0] frame_index
);
reg [3:0] busy;
always @(posedge clock or negedge nrst) begin
	if (!nrst) begin
		busy <= 4'h0;
		frame_index <= 14'h0;
		pipeline_idle <= 1'b1;
	end else begin
		if (core_reset)
			busy <= 4'h0;
		else if (schedule_run)
			busy <= slow ? 4'h8 : 4'h2;
		else if (busy != 4'h0)
			busy <= busy - 4'h1;
		if (schedule_run)
			frame_index <= frame_index + 14'h9;
		pipeline_idle <= busy == 4'h0 && !schedule_run;
	end
end
endmodule // core_model

// ### testbench/host_cmd_sts_sva.sv
// Purpose: Port checker for host_cmd_sts
// Assumes: Sees top ports only
// Notes:   Bound after endmodule
`timescale 1ns/100ps
module host_cmd_sts_chk (
	input wire clock, nrst, wr, rd, internal_error, programmable_list_capable,
	input wire [7:0] addr,
	input wire [31:0] wdata, rdata,
	input wire schedule_run, core_reset, abort_transaction, ports_to_companion,
	input wire [1:0] frame_list_size,
	input wire [13:0] frame_index,
	input wire [9:0] list_index
);
default clocking @(posedge clock); endclocking
default disable iff (!nrst);
wire cw = wr && addr == 8'h20 && !core_reset;
property p_lock; !programmable_list_capable && $past(!programmable_list_capable) |-> $stable(frame_list_size); endproperty
a_lock: assert property (p_lock) else $error("size moved while locked");
property p_idx; 1 |=> list_index == ($past(frame_index[12:3]) & ($past(frame_list_size) == 2'h0 ? 10'h3ff
	: $past(frame_list_size) == 2'h1 ? 10'h1ff : 10'h0ff)); endproperty
a_idx: assert property (p_idx) else $error("list index wrong");
property p_srst; cw && wdata[1] |-> ##2 core_reset; endproperty
a_srst: assert property (p_srst) else $error("reset not started");
property p_len; $rose(core_reset) |-> core_reset[*8] ##1 core_reset[*8] ##1 !core_reset; endproperty
a_len: assert property (p_len) else $error("reset length wrong");
property p_abort; 1 |-> abort_transaction == core_reset; endproperty
a_abort: assert property (p_abort) else $error("abort not with reset");
property p_ports; $rose(core_reset) |-> ports_to_companion; endproperty
a_ports: assert property (p_ports) else $error("ports kept");
property p_run; cw && wdata[1:0] == 2'b01 && !internal_error |-> ##2 schedule_run; endproperty
a_run: assert property (p_run) else $error("run not honoured");
property p_stop; cw && wdata[1:0] == 2'b00 |-> ##2 !schedule_run; endproperty
a_stop: assert property (p_stop) else $error("stop not honoured");
property p_rsv; rd && addr == 8'h24 |=> rdata[31:16] == 16'h0 && rdata[11:6] == 6'h0; endproperty
a_rsv: assert property (p_rsv) else $error("reserved status set");
endmodule // host_cmd_sts_chk
bind host_cmd_sts host_cmd_sts_chk chk (.*);

// ### testbench/usb_host_command_status_regs_tb_top.sv
// Purpose: Self-checking bench for host_cmd_sts
// Assumes: Inputs change at falling edge
// Notes:   Core model drains slowly
`timescale 1ns/100ps
module usb_host_command_status_regs_tb_top;
reg clock = 0, nrst = 0, wr = 0, rd = 0, programmable_list_capable = 0, internal_error = 0, slow = 0;
reg async_sched_state = 0, periodic_sched_state = 0, empty_async_detect = 0;
reg [7:0] addr = 8'h0;
reg [31:0] wdata = 32'h0, d;
reg [5:0] event_in = 6'h0;
wire pipeline_idle, schedule_run, core_reset, abort_transaction, ports_to_companion;
wire [13:0] frame_index;
wire [31:0] rdata;
wire [1:0] frame_list_size;
wire [9:0] list_index;
integer failures = 0, total_checks = 0, i;
host_cmd_sts DUT (.*);
core_model MODEL (.*);
initial forever #25 clock = ~clock;
task chk(input string n, input [31:0] s, input [31:0] e);
	total_checks++;
	if (s !== e) begin
		failures++;
		$display("MISMATCH %s exp %h seen %h", n, e, s);
	end
endtask
task wreg(input [7:0] a, input [31:0] v);
	@(negedge clock) {addr, wdata, wr} = {a, v, 1'b1};
	@(negedge clock) wr = 0;
endtask
task rreg(input [7:0] a);
	@(negedge clock) {addr, rd} = {a, 1'b1};
	@(negedge clock) rd = 0;
	d = rdata;
endtask
task wait_halt;
	d = 0;
	for (i = 0; i < 30 && !d[12]; i++) rreg(8'h24);
endtask
task t_reset;
	rreg(8'h24);
	chk("status", d, 32'h1000);
	rreg(8'h20);
	chk("command", d, 32'h0);
	rreg(8'h00);
	chk("unmapped", d, 32'h0);
	$display("t_reset done");
endtask
task t_size;
	wreg(8'h20, 32'h8);
	rreg(8'h20);
	chk("locked size", d, 32'h0);
	programmable_list_capable = 1;
	for (int c = 2; c >= 0; c--) begin
		wreg(8'h20, c << 2);
		rreg(8'h20);
		chk("size", d, c << 2);
		chk("size out", frame_list_size, c);
	end
	$display("t_size done");
endtask
task t_run;
	slow = 1;
	rreg(8'h24);
	chk("halted before run", d[12], 1'b1);
	wreg(8'h20, 32'h1);
	rreg(8'h24);
	chk("halted run", d[12], 1'b0);
	chk("run out", schedule_run, 1'b1);
	wreg(8'h20, 32'h0);
	rreg(8'h24);
	chk("draining", d[12], 1'b0);
	wait_halt;
	chk("halted stop", d[12], 1'b1);
	chk("index", list_index, (frame_index >> 3) & 32'h3ff);
	wreg(8'h20, 32'h1);
	@(negedge clock) internal_error = 1;
	@(negedge clock) internal_error = 0;
	wait_halt;
	chk("halted error", d[12], 1'b1);
	$display("t_run done");
endtask
task t_events;
	{async_sched_state, periodic_sched_state, empty_async_detect} = 3'b111;
	@(negedge clock) event_in = 6'h3f;
	@(negedge clock) event_in = 6'h0;
	wreg(8'h24, 32'h0);
	rreg(8'h24);
	chk("events", d, 32'hf03f);
	wreg(8'h24, 32'h15);
	rreg(8'h24);
	chk("clear", d, 32'hf02a);
	{async_sched_state, periodic_sched_state, empty_async_detect} = 3'b000;
	$display("t_events done");
endtask
task t_srst;
	rreg(8'h24);
	chk("halted before reset", d[12], 1'b1);
	wreg(8'h20, 32'h4);
	wreg(8'h20, 32'h2);
	wreg(8'h20, 32'h0);
	rreg(8'h20);
	chk("busy", d, 32'h2);
	chk("core reset", core_reset, 1'b1);
	chk("abort", abort_transaction, 1'b1);
	chk("companion", ports_to_companion, 1'b1);
	repeat (20) @(negedge clock);
	rreg(8'h20);
	chk("cmd after", d, 32'h0);
	rreg(8'h24);
	chk("sts after", d, 32'h1000);
	$display("t_srst done");
endtask
task print_verdict;
	$display("checks %0d failures %0d", total_checks, failures);
	if (failures == 0 && total_checks > 0)
		$display("All checks passed");
	else
		$display("Checks failed");
	$finish;
endtask
initial begin
	repeat (2) @(negedge clock);
	nrst = 1;
	t_reset;
	t_size;
	t_run;
	t_events;
	t_srst;
	print_verdict;
end
initial begin
	#100000;
	failures++;
	print_verdict;
end
endmodule // usb_host_command_status_regs_tb_top
